// ===== hw/mrc_rx_ctrl.v
// Purpose: Receive control of an Ethernet MAC: enable, size limit, cut, strip
// Assumes: PHY side byte stream on core_clk; status word to fifo_controller
// Notes: Registers reached over Avalon-MM, one wait state on every access
//
// How it works
// - Maximum size field 29:16 limits frames; reset value 1518.
// - Watchdog cuts and aborts any frame longer than 11264 bytes.
// - Select bit 0: cut at allowed size plus one, at most 11265; long flag set.
// - Select bit 1, reset value: cut at 11265, long and watchdog flags.
// - Strip bit 4 removes the last four bytes; resets to zero.
// - Enforcement bit 2 clear: abort every frame over maximum size.
// - Enforcement set: allow maximum, plus four, plus eight by tag count.
// - Frames accepted only while enable bit 0 is set; resets zero.
// - Enable cleared mid frame: finish frame, then disable and flag.
// - Disabled flag bit 1 set at shutdown end; write one clears.
`default_nettype none
`include "mrc_defs.vh"
module mrc_rx_ctrl (
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Avalon-MM slave
  input wire [11:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // PHY receive bytes, from another clock region
  input wire phy_rx_dv,
  input wire [7:0] phy_rx_data,
  input wire [1:0] phy_vlan_tags,
  // Frame path to fifo_controller
  output reg out_valid,
  output reg [7:0] out_data,
  output reg out_last,
  output reg stat_valid,
  output reg [31:0] rx_status_word_a,
  // Interrupt
  output wire irq
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; stage one is read only by stage two
  reg dv_s1_reg;
  reg dv_s2_reg;
  reg [7:0] dat_s1_reg;
  reg [7:0] dat_s2_reg;
  reg [1:0] tag_s1_reg;
  reg [1:0] tag_s2_reg;
  always @(posedge core_clk) begin
    if (srst) begin
      dv_s1_reg <= 1'b0;
      dv_s2_reg <= 1'b0;
      dat_s1_reg <= 8'h00;
      dat_s2_reg <= 8'h00;
      tag_s1_reg <= 2'h0;
      tag_s2_reg <= 2'h0;
    end else begin
      dv_s1_reg <= phy_rx_dv;
      dv_s2_reg <= dv_s1_reg;
      dat_s1_reg <= phy_rx_data;
      dat_s2_reg <= dat_s1_reg;
      tag_s1_reg <= phy_vlan_tags;
      tag_s2_reg <= tag_s1_reg;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Control and interrupt registers
  reg [13:0] max_reg;
  reg trunc_reg;
  reg strip_reg;
  reg vlan_reg;
  reg rxon_reg;
  reg rxoff_reg;
  reg [`MRC_IRQ_W-1:0] istat_reg;
  reg [`MRC_IRQ_W-1:0] imask_reg;
  reg ack_reg;
  wire req = (avs_read || avs_write) && !ack_reg;
  wire wr_hit = avs_write && ack_reg;
  wire ctrl_sel = avs_address == `MRC_CTRL_OFS;
  wire ist_sel = avs_address == `MRC_IRQ_STAT_OFS;
  wire imk_sel = avs_address == `MRC_IRQ_MASK_OFS;
  wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] wmask = avs_writedata & be_mask;
  wire [31:0] ctrl_mask = be_mask & `MRC_CTRL_WMASK;
  wire shut_done;
  wire abort_evt;
  // One wait state: waitrequest high in the first cycle of a request
  assign avs_waitrequest = req;
  always @(posedge core_clk) begin
    if (srst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end
  // Settings writes; is left to software, nothing blocks them
  always @(posedge core_clk) begin
    if (srst) begin
      max_reg <= `MRC_MAX_RST;
      trunc_reg <= `MRC_TRUNC_RST;
      strip_reg <= 1'b0;
      vlan_reg <= 1'b0;
      rxon_reg <= 1'b0;
      imask_reg <= {`MRC_IRQ_W{1'b0}};
    end else if (wr_hit && ctrl_sel) begin
      if (ctrl_mask[`MRC_MAX_LSB]) begin
        max_reg[7:0] <= avs_writedata[23:16];
      end
      if (ctrl_mask[24]) begin
        max_reg[13:8] <= avs_writedata[`MRC_MAX_MSB:24];
      end
      if (ctrl_mask[0]) begin
        trunc_reg <= avs_writedata[`MRC_BIT_TRUNC];
        strip_reg <= avs_writedata[`MRC_BIT_STRIP];
        vlan_reg <= avs_writedata[`MRC_BIT_VLAN];
        rxon_reg <= avs_writedata[`MRC_BIT_RXON];
      end
    end else if (wr_hit && imk_sel && avs_byteenable[0]) begin
      imask_reg <= avs_writedata[`MRC_IRQ_W-1:0];
    end
  end
  // Sticky flags; a set in the clearing cycle wins
  always @(posedge core_clk) begin
    if (srst) begin
      rxoff_reg <= 1'b0;
      istat_reg <= {`MRC_IRQ_W{1'b0}};
    end else begin
      if (shut_done) begin
        rxoff_reg <= 1'b1;
      end else if (wr_hit && ctrl_sel && wmask[`MRC_BIT_RXOFF]) begin
        rxoff_reg <= 1'b0;
      end
      istat_reg <= (istat_reg &
        ~((wr_hit && ist_sel) ? wmask[`MRC_IRQ_W-1:0] : {`MRC_IRQ_W{1'b0}}))
        | {abort_evt, shut_done};
    end
  end
  assign irq = |(istat_reg & imask_reg);
  // Read data registered at the answering edge; unmapped reads zero
  always @(posedge core_clk) begin
    if (srst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack_reg) begin
      if (ctrl_sel) begin
        avs_readdata <= {2'b00, max_reg, 10'h000, trunc_reg, strip_reg,
                         1'b0, vlan_reg, rxoff_reg, rxon_reg};
      end else if (ist_sel) begin
        avs_readdata <= {30'h0, istat_reg};
      end else if (imk_sel) begin
        avs_readdata <= {30'h0, imask_reg};
      end else begin
        avs_readdata <= 32'h00000000;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Receiver state: off, idle, in frame, dropping rest of a cut frame
  localparam [3:0] ST_OFF = 4'b0001;
  localparam [3:0] ST_IDLE = 4'b0010;
  localparam [3:0] ST_FRAME = 4'b0100;
  localparam [3:0] ST_DROP = 4'b1000;
  reg [3:0] st_reg;
  reg [3:0] st_next;
  reg [13:0] cnt_reg;
  reg [1:0] tags_reg;
  reg long_reg;
  reg wdog_reg;
  reg [31:0] hold_reg; // Last four bytes held back for stripping
  reg [2:0] held_reg;
  reg dv_d_reg;
  wire [13:0] limit;
  wire [13:0] cut_len;
  wire over;
  wire cut;
  wire [13:0] cnt_inc = cnt_reg + 14'd1;
  mrc_len_check u_len (
    .max_size(max_reg),
    .vlan_enforce(vlan_reg),
    .trunc_sel(trunc_reg),
    .byte_cnt(cnt_inc),
    .vlan_tags(tags_reg),
    .limit(limit),
    .cut_len(cut_len),
    .over(over),
    .cut(cut)
  );
  wire sof = dv_s2_reg && !dv_d_reg;
  wire byte_in = dv_s2_reg && (st_reg == ST_FRAME);
  wire eof = (st_reg == ST_FRAME) && !dv_s2_reg;
  wire cut_now = byte_in && cut;
  wire frame_end = eof || cut_now;
  // Shutdown completes at idle, or right after the frame in progress
  assign shut_done = !rxon_reg &&
    ((st_reg == ST_IDLE) || ((st_reg == ST_DROP) && !dv_s2_reg) ||
     (frame_end && 1'b1));
  assign abort_evt = frame_end && (long_reg || (byte_in && over));
  always @* begin
    st_next = st_reg;
    case (st_reg)
      ST_OFF: begin
        if (rxon_reg && !dv_s2_reg) begin
          st_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (!rxon_reg) begin
          st_next = ST_OFF;
        end else if (sof) begin
          st_next = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (cut_now) begin
          st_next = rxon_reg ? ST_DROP : ST_OFF;
        end else if (eof) begin
          st_next = rxon_reg ? ST_IDLE : ST_OFF;
        end
      end
      ST_DROP: begin
        if (!dv_s2_reg) begin
          st_next = rxon_reg ? ST_IDLE : ST_OFF;
        end
      end
      default: begin
        st_next = ST_OFF;
      end
    endcase
  end
  // Frame counting, flags and output stream
  always @(posedge core_clk) begin
    if (srst) begin
      st_reg <= ST_OFF;
      dv_d_reg <= 1'b0;
      cnt_reg <= 14'h0000;
      tags_reg <= 2'h0;
      long_reg <= 1'b0;
      wdog_reg <= 1'b0;
      hold_reg <= 32'h00000000;
      held_reg <= 3'h0;
      out_valid <= 1'b0;
      out_data <= 8'h00;
      out_last <= 1'b0;
      stat_valid <= 1'b0;
      rx_status_word_a <= 32'h00000000;
    end else begin
      st_reg <= st_next;
      dv_d_reg <= dv_s2_reg;
      out_valid <= 1'b0;
      out_last <= 1'b0;
      stat_valid <= 1'b0;
      if (st_reg == ST_IDLE && sof && rxon_reg) begin
        cnt_reg <= 14'h0000;
        tags_reg <= tag_s2_reg;
        long_reg <= 1'b0;
        wdog_reg <= 1'b0;
        held_reg <= 3'h0;
      end
      if (byte_in) begin
        cnt_reg <= cnt_inc;
        tags_reg <= tag_s2_reg;
        if (over) begin
          long_reg <= 1'b1;
        end
        hold_reg <= {hold_reg[23:0], dat_s2_reg};
        // With stripping, a byte leaves only once four newer ones exist
        if (!strip_reg) begin
          out_valid <= 1'b1;
          out_data <= dat_s2_reg;
          out_last <= cut_now;
        end else if (held_reg == 3'd4) begin
          out_valid <= 1'b1;
          out_data <= hold_reg[31:24];
        end else begin
          held_reg <= held_reg + 3'd1;
        end
      end
      // Status word: length, long, watchdog, abort
      if (frame_end) begin
        stat_valid <= 1'b1;
        rx_status_word_a <= 32'h00000000;
        rx_status_word_a[13:0] <= cut_now ? cut_len :
          (strip_reg && cnt_reg >= `MRC_FCS_BYTES) ?
          cnt_reg - `MRC_FCS_BYTES : cnt_reg;
        rx_status_word_a[`MRC_ST_LONG] <= long_reg || (byte_in && over);
        rx_status_word_a[`MRC_ST_WDOG] <= cut_now && trunc_reg;
        rx_status_word_a[`MRC_ST_ABORT] <= abort_evt;
        if (frame_end) begin
          out_last <= 1'b1; // Marks every frame end, stripped or cut
        end
      end
    end
  end
endmodule // mrc_rx_ctrl
`default_nettype wire

// ===== hw/mrc_defs.vh
// Purpose: Constants for the receive control block
// Assumes: 32-bit Avalon-MM word registers, byte addressed
// Notes: Included by both design files
`ifndef MRC_DEFS_VH
`define MRC_DEFS_VH
`define MRC_CTRL_OFS 12'h104
`define MRC_IRQ_STAT_OFS 12'h110
`define MRC_IRQ_MASK_OFS 12'h114
`define MRC_BIT_RXON 0
`define MRC_BIT_RXOFF 1
`define MRC_BIT_VLAN 2
`define MRC_BIT_STRIP 4
`define MRC_BIT_TRUNC 5
`define MRC_MAX_LSB 16
`define MRC_MAX_MSB 29
`define MRC_CTRL_WMASK 32'h3fff0035
`define MRC_MAX_RST 14'h05ee
`define MRC_TRUNC_RST 1'b1
`define MRC_WDOG_BYTES 14'h2c00
`define MRC_WDOG_CUT 14'h2c01
`define MRC_VLAN_ADD1 14'h0004
`define MRC_VLAN_ADD2 14'h0008
`define MRC_FCS_BYTES 14'h0004
`define MRC_ST_LONG 14
`define MRC_ST_WDOG 15
`define MRC_ST_ABORT 16
`define MRC_IRQ_RXOFF 0
`define MRC_IRQ_ABORT 1
`define MRC_IRQ_W 2
`endif

// ===== hw/mrc_len_check.v
// Purpose: Frame length limit and cut point for one received frame
// Assumes: Byte count and tag count come from the frame path
// Notes: Pure combinational; no state
`default_nettype none
`include "mrc_defs.vh"
module mrc_len_check (
  // Settings
  input wire [13:0] max_size,
  input wire vlan_enforce,
  input wire trunc_sel,
  // Frame state
  input wire [13:0] byte_cnt,
  input wire [1:0] vlan_tags,
  // Results
  output reg [13:0] limit,
  output reg [13:0] cut_len,
  output wire over,
  output wire cut
);
  ////////////////////////////////////////////////////////////////////////
  // Allowance grows with tag count only when enforcement is on
  reg [14:0] sum_ext;
  always @* begin
    sum_ext = {1'b0, max_size};
    if (vlan_enforce && vlan_tags == 2'd1) begin
      sum_ext = {1'b0, max_size} + {1'b0, `MRC_VLAN_ADD1};
    end else if (vlan_enforce && vlan_tags >= 2'd2) begin
      sum_ext = {1'b0, max_size} + {1'b0, `MRC_VLAN_ADD2};
    end
    // Saturate, so a large maximum never wraps to a tiny limit
    limit = sum_ext[14] ? 14'h3fff : sum_ext[13:0];
  end
  // Cut point: the watchdog length when selected or when it comes first, else limit plus one
  always @* begin
    if (trunc_sel || (limit >= `MRC_WDOG_BYTES)) begin
      cut_len = `MRC_WDOG_CUT;
    end else begin
      cut_len = limit + 14'd1;
    end
  end
  // Over is judged on the count including the byte now arriving; limit includes the tag allowance
  assign over = (byte_cnt > limit) || (byte_cnt > `MRC_WDOG_BYTES);
  assign cut = (byte_cnt >= cut_len) || (byte_cnt >= `MRC_WDOG_CUT);
endmodule // mrc_len_check
`default_nettype wire

// ===== tb/mrc_rx_ctrl_asserts.sv
// Purpose: Port checks of the receive control block
// Assumes: One clock, sync reset
// Notes: Enable bit shadowed from completed bus writes
`default_nettype none
`include "mrc_defs.vh"
module mrc_rx_ctrl_asserts (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register bus
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Stream
  input wire logic phy_rx_dv,
  input wire logic out_valid,
  input wire logic stat_valid,
  input wire logic [31:0] rx_status_word_a
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic en_reg, quiet_reg;
  logic [2:0] low_reg;
  logic [13:0] cnt_reg;
  wire req = avs_read | avs_write;
  wire [16:0] st = rx_status_word_a[16:0];
  wire ctrl_wr = avs_write && !avs_waitrequest &&
    avs_address == `MRC_CTRL_OFS;
  //////////////////////////////////////////////////////////////////////////
  // Quiet only once the line idled past the sync delay
  always_ff @(posedge core_clk) begin
    if (srst) begin
      en_reg <= 1'b0;
      quiet_reg <= 1'b0;
      low_reg <= 3'h0;
      cnt_reg <= 14'h0;
    end else begin
      en_reg <= ctrl_wr ? avs_writedata[0] : en_reg;
      low_reg <= phy_rx_dv ? 3'h0 : low_reg + {2'h0, low_reg != 3'h7};
      quiet_reg <= !en_reg && (quiet_reg || low_reg == 3'h7);
      cnt_reg <= stat_valid ? 14'h0 : cnt_reg + {13'h0, out_valid};
    end
  end
  sequence s_wait; avs_waitrequest; endsequence
  sequence s_go; !avs_waitrequest; endsequence
  wait_state_a: assert property (req && !$past(req) |-> s_wait ##1 s_go)
    else $error("bus answer not after one wait");
  rsvd_zero_a: assert property (avs_read && !avs_waitrequest &&
    avs_address == `MRC_CTRL_OFS |-> (avs_readdata & 32'hc000ffc8) == 0)
    else $error("reserved bits read nonzero");
  len_cap_a: assert property (stat_valid |-> st[13:0] <= 14'h2c01)
    else $error("length above watchdog cut");
  wdog_flags_a: assert property (stat_valid && st[15] |->
    st[14] && st[13:0] == 14'h2c01) else $error("watchdog status wrong");
  long_abort_a: assert property (stat_valid && st[14] |-> st[16])
    else $error("long frame not aborted");
  byte_count_a: assert property (stat_valid |->
    cnt_reg + {13'h0, out_valid} == st[13:0]) else $error("byte count");
  off_quiet_a: assert property (quiet_reg |-> !out_valid && !stat_valid)
    else $error("frame passed while off");
  stat_pulse_a: assert property (stat_valid |=> !stat_valid)
    else $error("status not one pulse");
endmodule // mrc_rx_ctrl_asserts
bind mrc_rx_ctrl mrc_rx_ctrl_asserts mrc_rx_ctrl_asserts_i (.core_clk,
  .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .phy_rx_dv, .out_valid, .stat_valid,
  .rx_status_word_a);
`default_nettype wire

// ===== tb/mrc_phy_model.sv
// Purpose: Byte source standing in for the PHY receive side
// Assumes: Bytes on core_clk, tag count held over a frame
// Notes: Data shows its inverse between frames
`default_nettype none
module mrc_phy_model (
  // Clock
  input wire logic core_clk,
  // Byte stream
  output logic phy_rx_dv,
  output logic [7:0] phy_rx_data,
  output logic [1:0] phy_vlan_tags
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    phy_rx_dv = 1'b0;
    phy_rx_data = 8'h5a;
    phy_vlan_tags = 2'h0;
  end
  // Lead byte only arms the frame, so n bytes take n+1 cycles
  task automatic send(input int n, input logic [1:0] tags);
    for (int i = 0; i <= n; i++) begin
      @(posedge core_clk);
      phy_rx_dv <= 1'b1;
      phy_rx_data <= i[7:0] ^ 8'h3c;
      phy_vlan_tags <= tags;
    end
    @(posedge core_clk);
    phy_rx_dv <= 1'b0;
    phy_rx_data <= ~phy_rx_data;
    // Gap lets the delayed status come out
    repeat (12) @(posedge core_clk);
  endtask
endmodule // mrc_phy_model
`default_nettype wire

// ===== tb/mrc_rx_ctrl_bench.sv
// Purpose: Self checking bench of the receive control block
// Assumes: Avalon-MM access, bytes from the PHY model
// Notes: Watchdog frame runs at full size, about 11k cycles
`default_nettype none
`include "mrc_defs.vh"
module mrc_rx_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] avs_address = 12'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rx_status_word_a, d, st;
  logic [31:0] cur = 32'h00400000;
  logic avs_waitrequest, phy_rx_dv, out_valid, stat_valid, irq, out_last;
  logic [7:0] phy_rx_data, out_data;
  logic [1:0] phy_vlan_tags;
  int num_errors = 0;
  int tests_run = 0;
  int nbytes, nstat, nlast;
  //////////////////////////////////////////////////////////////////////////
  always #50 core_clk = ~core_clk;
  mrc_phy_model mrc_phy_model_i (.core_clk, .phy_rx_dv, .phy_rx_data,
    .phy_vlan_tags);
  mrc_rx_ctrl mrc_rx_ctrl_i (.core_clk, .srst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
    .avs_waitrequest, .phy_rx_dv, .phy_rx_data, .phy_vlan_tags, .out_valid,
    .out_data, .out_last, .stat_valid, .rx_status_word_a, .irq);
  // Count bytes and ends, keep the last status word; the arming byte
  // never leaves, so byte k out carries the model's pattern for k
  always @(posedge core_clk) begin
    if (out_valid === 1'b1) begin
      chk({24'h0, out_data}, ((nbytes + 1) ^ 32'h3c) & 32'hff);
      nbytes++;
    end
    if (out_last === 1'b1) nlast++;
    if (stat_valid === 1'b1) begin
      st = rx_status_word_a;
      nstat++;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    v = avs_readdata;
    avs_read <= 1'b0;
  endtask
  // Settings change only with the receiver off
  task automatic cfg(input logic [31:0] v);
    wr(`MRC_CTRL_OFS, cur);
    cur = v;
    wr(`MRC_CTRL_OFS, v);
    wr(`MRC_CTRL_OFS, v | 32'h3);
  endtask
  task automatic frame(input int n, input logic [1:0] t,
      input logic [31:0] eb, input logic [16:0] es);
    nbytes = 0;
    nstat = 0;
    nlast = 0;
    mrc_phy_model_i.send(n, t);
    chk(nbytes, eb);
    chk(nstat, 32'h1);
    chk(nlast, 32'h1);
    chk({15'h0, st[16:0]}, {15'h0, es});
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard well past the longest frame
  initial begin
    repeat (40000) @(posedge core_clk);
    num_errors++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    rd(`MRC_CTRL_OFS, d);
    chk(d, 32'h05ee0020);
    wr(`MRC_CTRL_OFS, 32'hffffffc8);
    rd(`MRC_CTRL_OFS, d);
    chk(d, 32'h3fff0000);
    rd(12'h200, d);
    chk(d, 32'h0);
    wr(`MRC_CTRL_OFS, cur);
    nbytes = 0;
    nstat = 0;
    mrc_phy_model_i.send(60, 2'h0);
    chk(nbytes + nstat, 32'h0);
    cfg(32'h00400000);
    frame(64, 2'h0, 64, 17'h00040);
    frame(65, 2'h0, 65, 17'h14041);
    rd(`MRC_IRQ_STAT_OFS, d);
    chk(d, 32'h2);
    frame(66, 2'h2, 65, 17'h14041);
    cfg(32'h00400004);
    frame(68, 2'h1, 68, 17'h00044);
    frame(72, 2'h2, 72, 17'h00048);
    frame(65, 2'h0, 65, 17'h14041);
    cfg(32'h00400010);
    frame(60, 2'h0, 56, 17'h00038);
    cfg(32'h3fff0020);
    frame(11300, 2'h0, 11265, 17'h1ec01);
    cfg(32'h00400000);
    wr(`MRC_IRQ_STAT_OFS, 32'h3);
    nbytes = 0;
    fork
      mrc_phy_model_i.send(40, 2'h0);
      begin
        repeat (10) @(posedge core_clk);
        wr(`MRC_CTRL_OFS, 32'h00400000);
      end
    join
    chk(nbytes, 32'd40);
    rd(`MRC_CTRL_OFS, d);
    chk(d, 32'h00400002);
    rd(`MRC_IRQ_STAT_OFS, d);
    chk(d | {31'h0, irq}, 32'h1);
    wr(`MRC_IRQ_MASK_OFS, 32'h1);
    rd(`MRC_IRQ_MASK_OFS, d);
    chk(d, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(`MRC_IRQ_STAT_OFS, 32'h1);
    wr(`MRC_CTRL_OFS, 32'h00400002);
    rd(`MRC_CTRL_OFS, d);
    chk(d | {31'h0, irq}, 32'h00400000);
    report_and_stop;
  end
endmodule // mrc_rx_ctrl_bench
`default_nettype wire
